// file: include/slt_pkg.sv
/*
  Sleep timer constants: register offsets, field positions, reset
  values and clock figures.
  Assumes a byte-wide register port with byte addresses.
*/
`default_nettype none
package slt_pkg;

  localparam int          CNT_W          = 24;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CNT_LOW   = 8'h95;
  localparam logic [7:0]  ADDR_CNT_MID   = 8'h96;
  localparam logic [7:0]  ADDR_CNT_HIGH  = 8'h97;
  localparam logic [7:0]  ADDR_IRQ_FLAG  = 8'hC0;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'hC1;
  localparam logic [7:0]  ADDR_PWR_STAT  = 8'hC2;

  // Status and enable layout
  localparam int          BIT_CMP        = 0;
  localparam int          BIT_WRAP       = 1;
  localparam int          IRQ_W          = 2;

  // Reset values
  localparam logic [23:0] RST_CMP        = 24'hFFFFFF;
  localparam logic [23:0] RST_CNT        = 24'h000000;
  localparam logic [1:0]  RST_IRQ        = 2'h0;
  localparam logic [7:0]  RST_RDATA      = 8'h00;

  // Source numbers seen by the interrupt and DMA controllers
  localparam logic [4:0]  IRQ_SRC_NUM    = 5'h05;
  localparam logic [4:0]  DMA_TRIG_NUM   = 5'h09;

  // Power modes
  typedef enum logic [1:0] {
    SLT_PM_ACTIVE = 2'b00,
    SLT_PM_ONE    = 2'b01,
    SLT_PM_TWO    = 2'b10,
    SLT_PM_OTHER  = 2'b11
  } slt_pmode_t;

  // Clock figures
  localparam int          SYS_CLK_HZ     = 20_000_000;
  localparam int          LF_CLK_HZ      = 32_768;
  // Shortest low-frequency half period, in system cycles, rounded down
  localparam int          LF_HALF_CYC    = SYS_CLK_HZ / (2 * LF_CLK_HZ);

endpackage
`default_nettype wire

// file: include/slt_if.sv
/*
  Carrier between the sleep timer top and its counter core.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface slt_if;
  logic        tick;
  logic        cmp_load;
  logic [23:0] cmp_val;
  logic [23:0] count;
  logic        cmp_hit;
  logic        wrap;

  modport ctrl (output tick, output cmp_load, output cmp_val,
                input count, input cmp_hit, input wrap);
  modport core (input tick, input cmp_load, input cmp_val,
                output count, output cmp_hit, output wrap);
endinterface
`default_nettype wire

// file: design/slt_counter.sv
/*
  Sleep counter core: 24-bit free-running count and compare.
  Assumes tick is a one-cycle pulse per low-frequency clock period.
*/
`timescale 1ns/10ps
`default_nettype none
module slt_counter (
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  slt_if.core       bus
);

  logic [23:0] count;
  logic [23:0] cmp;
  logic [23:0] next_count;
  logic        cmp_hit;
  logic        wrap;

  // Wraps to zero after all ones; no halt input exists
  assign next_count = count + 24'h000001;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      count <= slt_pkg::RST_CNT;
    end else if (bus.tick) begin
      count <= next_count;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cmp <= slt_pkg::RST_CMP;
    end else if (bus.cmp_load) begin
      cmp <= bus.cmp_val;
    end
  end

  // One event per match, not one per system cycle of the match
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cmp_hit <= 1'b0;
      wrap    <= 1'b0;
    end else begin
      cmp_hit <= bus.tick && (next_count == cmp);
      wrap    <= bus.tick && (count == 24'hFFFFFF);
    end
  end

  assign bus.count   = count;
  assign bus.cmp_hit = cmp_hit;
  assign bus.wrap    = wrap;

endmodule
`default_nettype wire

// file: design/slt_sleep_timer.sv
/*
  Sleep timer top: low-frequency clock sampling, byte register port,
  compare staging, interrupt, DMA trigger and wake request.
  Assumes i_clk_lf is a free 32.768 kHz square wave from a pin, much
  slower than i_clk_sys, and a master that never overlaps strobes.

*/
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module slt_sleep_timer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_clk_lf,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [1:0]  i_power_mode,
  output logic             o_wake,
  output logic             o_irq,
  output logic      [4:0]  o_irq_src,
  output logic             o_dma_trig,
  output logic      [4:0]  o_dma_trig_src,
  output logic      [23:0] o_mac_sleep_count,
  output logic             o_mac_sleep_tick
);

  slt_if link ();

  function automatic logic [7:0] pick_byte(input logic [23:0] v,
                                           input logic [1:0]  idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      2'b00:   b = v[7:0];
      2'b01:   b = v[15:8];
      2'b10:   b = v[23:16];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // LF sync resets high: a level held over reset is not an edge
  logic lf_meta;
  logic lf_sync;
  logic lf_prev;
  logic lf_tick;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      lf_meta <= 1'b1;
      lf_sync <= 1'b1;
    end else begin
      lf_meta <= i_clk_lf;
      lf_sync <= lf_meta;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      lf_prev <= 1'b1;
    end else begin
      lf_prev <= lf_sync;
    end
  end

  // Rising edges only; no enable of any kind gates it
  assign lf_tick   = lf_sync && !lf_prev;
  assign link.tick = lf_tick;

  ////////////////////////////////////////////////////////////////////
  // Counter core
  slt_counter u_counter (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .bus       (link.core)
  );

  ////////////////////////////////////////////////////////////////////
  // Address decode
  logic hit_low;
  logic hit_mid;
  logic hit_high;
  logic hit_flag;
  logic hit_en;
  logic hit_pwr;

  assign hit_low  = (i_addr == slt_pkg::ADDR_CNT_LOW);
  assign hit_mid  = (i_addr == slt_pkg::ADDR_CNT_MID);
  assign hit_high = (i_addr == slt_pkg::ADDR_CNT_HIGH);
  assign hit_flag = (i_addr == slt_pkg::ADDR_IRQ_FLAG);
  assign hit_en   = (i_addr == slt_pkg::ADDR_IRQ_EN);
  assign hit_pwr  = (i_addr == slt_pkg::ADDR_PWR_STAT);

  ////////////////////////////////////////////////////////////////////
  // Compare staging: middle and high wait for the low byte
  logic [7:0] stage_mid;
  logic [7:0] stage_high;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      stage_mid  <= slt_pkg::RST_CMP[15:8];
      stage_high <= slt_pkg::RST_CMP[23:16];
    end else if (i_wr) begin
      if (hit_mid) begin
        stage_mid <= i_wdata;
      end else if (hit_high) begin
        stage_high <= i_wdata;
      end
    end
  end

  // Low-byte write commits all three bytes at once
  assign link.cmp_load = i_wr && hit_low;
  assign link.cmp_val  = {stage_high, stage_mid, i_wdata};

  ////////////////////////////////////////////////////////////////////
  // Count snapshot taken by a low-byte read
  logic [23:0] snap;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      snap <= slt_pkg::RST_CNT;
    end else if (i_rd && hit_low) begin
      snap <= link.count;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status and enable
  logic [1:0] irq_flag;
  logic [1:0] irq_en;
  logic [1:0] irq_set;
  logic [1:0] next_irq_flag;

  assign irq_set = {link.wrap, link.cmp_hit};

  // A read clears; an event in the same cycle survives it
  always_comb begin
    next_irq_flag = irq_flag;
    if (i_rd && hit_flag) begin
      next_irq_flag = 2'h0;
    end
    next_irq_flag = next_irq_flag | irq_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      irq_flag <= slt_pkg::RST_IRQ;
    end else begin
      irq_flag <= next_irq_flag;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      irq_en <= slt_pkg::RST_IRQ;
    end else if (i_wr && hit_en) begin
      irq_en <= i_wdata[slt_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_irq_flag & irq_en);
    end
  end

  assign o_irq_src = slt_pkg::IRQ_SRC_NUM;

  ////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe and only then
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (hit_low) begin
      next_rdata = pick_byte(link.count, 2'b00);
    end else if (hit_mid) begin
      next_rdata = pick_byte(snap, 2'b01);
    end else if (hit_high) begin
      next_rdata = pick_byte(snap, 2'b10);
    end else if (hit_flag) begin
      next_rdata = {6'h00, irq_flag};
    end else if (hit_en) begin
      next_rdata = {6'h00, irq_en};
    end else if (hit_pwr) begin
      next_rdata = {6'h00, i_power_mode};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_rdata <= slt_pkg::RST_RDATA;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= slt_pkg::RST_RDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wake request and DMA trigger
  logic low_power;

  assign low_power = (i_power_mode == slt_pkg::SLT_PM_ONE) ||
                     (i_power_mode == slt_pkg::SLT_PM_TWO);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= link.cmp_hit && low_power;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_dma_trig <= 1'b0;
    end else begin
      o_dma_trig <= link.cmp_hit;
    end
  end

  assign o_dma_trig_src = slt_pkg::DMA_TRIG_NUM;

  ////////////////////////////////////////////////////////////////////
  // MAC timer view of the count
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_mac_sleep_count <= slt_pkg::RST_CNT;
      o_mac_sleep_tick  <= 1'b0;
    end else begin
      o_mac_sleep_count <= link.count;
      o_mac_sleep_tick  <= lf_tick;
    end
  end

  // Compare reset value and count wrap live in the core, so the
  // MAC view and register reads always share one counter

endmodule
`default_nettype wire

// file: bench/slt_sleep_timer_asserts.sv
/*
  Port checker for the sleep timer top.
  Assumes the bench runs the LF clock at 16 system cycles a period.
*/
`timescale 1ns/10ps
`default_nettype none
module slt_sleep_timer_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic [7:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [1:0]  i_power_mode,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_wake,
  input wire logic [4:0]  o_irq_src,
  input wire logic        o_dma_trig,
  input wire logic [4:0]  o_dma_trig_src,
  input wire logic [23:0] o_mac_sleep_count
);
  logic [23:0] prev;
  logic [5:0]  idle;
  // Counts cycles since the count last moved
  always_ff @(posedge i_clk_sys) begin
    prev <= o_mac_sleep_count;
    if (!i_rstn || prev != o_mac_sleep_count) idle <= 6'h00;
    else if (idle != 6'h3F) idle <= idle + 6'h01;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_irq_src_fixed: assert property (o_irq_src == 5'h05)
    else $error("irq source wrong");
  a_dma_src_fixed: assert property (o_dma_trig_src == 5'h09)
    else $error("dma source wrong");
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_dma_one_cycle: assert property (o_dma_trig |=> !o_dma_trig)
    else $error("dma trigger too long");
  a_wake_with_event: assert property (o_wake |-> o_dma_trig)
    else $error("wake without compare");
  a_wake_in_sleep: assert property (o_dma_trig && $stable(i_power_mode)
    && i_power_mode inside {2'h1, 2'h2} |-> o_wake)
    else $error("no wake in low power");
  a_count_steps: assert property (o_mac_sleep_count != $past(o_mac_sleep_count)
    |-> o_mac_sleep_count == $past(o_mac_sleep_count) + 24'h000001)
    else $error("count jumped");
  a_count_alive: assert property (idle < 6'h28)
    else $error("count stalled");
endmodule

bind slt_sleep_timer slt_sleep_timer_asserts i_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd),
  .i_power_mode(i_power_mode), .o_rdata(o_rdata), .o_wake(o_wake),
  .o_irq_src(o_irq_src), .o_dma_trig(o_dma_trig),
  .o_dma_trig_src(o_dma_trig_src), .o_mac_sleep_count(o_mac_sleep_count));
`default_nettype wire

// file: bench/slt_sleep_timer_tb.sv
/*
  Self-checking bench for the sleep timer top.
  Assumes one system clock and a free LF clock of 16 cycles a period.
*/
`timescale 1ns/10ps
`default_nettype none
module slt_sleep_timer_tb;
  logic        clk = 1'b0;
  logic        lf = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  pm = 2'h0;
  logic [7:0]  rdata, d;
  logic        wake, irq, dma, tick;
  logic [4:0]  isrc, dsrc;
  logic [23:0] mcnt, est, tgt;
  logic [23:0] lfc = 24'h000000;
  logic [23:0] ticks = 24'h000000;
  int          miscompares = 0;
  int          n_tests = 0;
  int          dmas = 0;
  int          seed = 32'h5a10;

  always #25 clk = ~clk;
  // Phase locked to the system clock, edges always on a falling system edge
  always #400 lf = ~lf;
  always @(posedge lf or negedge rstn)
    if (!rstn) lfc <= 24'h000000;
    else lfc <= lfc + 24'h000001;
  always @(posedge clk) if (dma === 1'b1) dmas <= dmas + 1;
  always @(posedge clk)
    if (!rstn) ticks <= 24'h000000;
    else if (tick === 1'b1) ticks <= ticks + 24'h000001;

  slt_sleep_timer i_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_clk_lf(lf), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_power_mode(pm), .o_wake(wake), .o_irq(irq), .o_irq_src(isrc),
    .o_dma_trig(dma), .o_dma_trig_src(dsrc),
    .o_mac_sleep_count(mcnt), .o_mac_sleep_tick(tick));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Design count lags the bench LF tally by at most one
  task automatic cnt_chk;
    logic [23:0] c;
    rd_reg(8'h95);
    est = lfc;
    c[7:0] = d;
    rd_reg(8'h96);
    c[15:8] = d;
    rd_reg(8'h97);
    c[23:16] = d;
    chk("count", 24'(est - c <= 24'h000001), 24'h1);
    chk("mac count", 24'(lfc - mcnt <= 24'h000001), 24'h1);
    chk("mac tick", 24'(lfc - ticks <= 24'h000001), 24'h1);
  endtask
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Tests need about 0.3 ms; three times that still ends a hang early
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end

  initial begin
    int k;
    int i;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cnt_chk();
    rd_reg(8'h10);
    chk("unmapped", d, 8'h00);
    wr_reg(8'hC0, 8'hFF);
    rd_reg(8'hC0);
    chk("flag write", d, 8'h00);
    // Snapshot taken just below a byte carry
    wait (lfc == 24'h0000FE);
    rd_reg(8'h95);
    wait (lfc == 24'h000104);
    rd_reg(8'h96);
    chk("held mid", d, 8'h00);
    rd_reg(8'h95);
    rd_reg(8'h96);
    chk("new mid", d, 8'h01);
    chk("no early event", 24'(dmas), 24'h0);
    $display("count tests done");
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      pm <= 2'(2 - k);
      wr_reg(8'hC1, {7'h00, k != 1});
      tgt = lfc + 24'h000008 + 24'($random(seed) & 15);
      wr_reg(8'h97, tgt[23:16]);
      wr_reg(8'h96, tgt[15:8]);
      wr_reg(8'h95, tgt[7:0]);
      i = 0;
      while (dma !== 1'b1 && i < 800) begin
        @(posedge clk);
        #1 i++;
      end
      chk("event", dma, 1'b1);
      chk("event time", 24'(lfc - tgt <= 24'h000001), 24'h1);
      chk("wake", wake, k != 2);
      chk("irq", irq, k != 1);
      rd_reg(8'hC2);
      chk("mode", d, pm);
      rd_reg(8'hC0);
      chk("flag", d & 8'h01, 8'h01);
      @(posedge clk);
      #1 chk("irq clear", irq, 1'b0);
      rd_reg(8'hC0);
      chk("flag clear", d, 8'h00);
      $display("compare test %0d done", k);
    end
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(8'hC1);
    chk("enable reset", d, 8'h00);
    cnt_chk();
    $display("reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
